// [src/flash_regs_pkg.sv]
// Package for the flash status and configuration register set.
// Holds bit positions, reset values and the operation state encoding.
package flash_regs_pkg;

  // ----------------------------------------------------------------
  // Status register one field positions
  // ----------------------------------------------------------------
  localparam int unsigned S1_LOCK_BIT    = 7;
  localparam int unsigned S1_PERR_BIT    = 6;
  localparam int unsigned S1_EERR_BIT    = 5;
  localparam int unsigned S1_BP_HI       = 4;
  localparam int unsigned S1_BP_LO       = 2;
  localparam int unsigned S1_LATCH_BIT   = 1;
  localparam int unsigned S1_BUSY_BIT    = 0;

  // ----------------------------------------------------------------
  // Configuration register field positions
  // ----------------------------------------------------------------
  localparam int unsigned CR_LAT_HI      = 7;
  localparam int unsigned CR_LAT_LO      = 6;
  localparam int unsigned CR_BOTTOM_BIT  = 5;
  localparam int unsigned CR_VOLSEL_BIT  = 3;
  localparam int unsigned CR_QUAD_BIT    = 1;
  localparam int unsigned CR_FREEZE_BIT  = 0;

  // ----------------------------------------------------------------
  // Status register two field positions
  // ----------------------------------------------------------------
  localparam int unsigned S2_ESUS_BIT    = 1;
  localparam int unsigned S2_PSUS_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] BP_NV_RESET     = 3'h0;
  localparam logic [2:0] BP_VOL_RESET    = 3'h7;
  localparam logic [1:0] LATENCY_RESET   = 2'h0;
  localparam logic       FLAG_RESET      = 1'b0;

  // Internal operation state
  typedef enum logic [1:0]
  {
    OP_IDLE    = 2'b00,
    OP_REGW    = 2'b01,
    OP_PROGRAM = 2'b10,
    OP_ERASE   = 2'b11
  } op_state_e;

endpackage

// [src/flash_status_config_regs.sv]
// Status and configuration register set of a serial NOR flash.
// Assumes a command decoder on clk delivers one-cycle command pulses
// with their data, and the array engine reports done and errors.
// Behaviour
// - Lock bit and low pin ignore register writes
// - Program or erase error sets its flag
// - Writes, program, erase need write enable latch
// - Only enable and disable commands change latch
// - Busy flag high while any operation runs and is not suspended
// - Protect level selects contiguous protected sector range
// - Volatile select makes protect bits volatile, default ones
// - Latency code selects read latency, default zero
// - Bottom bit starts range at low addresses
// - Quad enable selects quad or serial mode
// - Freeze locks protect bits, bottom bit, volatile select
// - Erase suspend flag follows erase suspend mode
// - Program suspend flag follows program suspend mode
`timescale 1ns/100ps

module flash_status_config_regs
#(
  parameter int unsigned SECTOR_BITS        = 8,
  parameter int unsigned WRITE_BUSY_CYCLES  = 16
)
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   write_protect_n,
  input  wire logic                   set_write_enable_cmd,
  input  wire logic                   clear_write_enable_cmd,
  input  wire logic                   write_registers_cmd,
  input  wire logic [7:0]             wr_status_data,
  input  wire logic [7:0]             wr_config_data,
  input  wire logic                   wr_config_valid,
  input  wire logic                   clear_status_cmd,
  input  wire logic                   program_cmd,
  input  wire logic                   erase_cmd,
  input  wire logic [SECTOR_BITS-1:0] target_sector,
  input  wire logic                   op_done,
  input  wire logic                   program_error,
  input  wire logic                   erase_error,
  input  wire logic                   erase_suspend,
  input  wire logic                   program_suspend,
  output logic [7:0]                  status_reg_one,
  output logic [7:0]                  config_reg,
  output logic [7:0]                  status_reg_two,
  output logic [1:0]                  read_latency_code,
  output logic                        quad_io_enable,
  output logic                        target_protected,
  output logic                        program_start,
  output logic                        erase_start
);

  import flash_regs_pkg::*;

  localparam int unsigned CNT_W = $clog2(WRITE_BUSY_CYCLES + 1);
  localparam logic [CNT_W-1:0] WRITE_BUSY_LOAD = CNT_W'(WRITE_BUSY_CYCLES);
  localparam logic [SECTOR_BITS:0] SECTOR_TOTAL = (SECTOR_BITS+1)'(1 << SECTOR_BITS);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                   wp_meta;
  logic                   wp_sync;
  logic                   status_write_lock;
  logic                   program_error_flag;
  logic                   erase_error_flag;
  logic [2:0]             bp_nv;
  logic [2:0]             bp_vol;
  logic [2:0]             block_protect_level;
  logic                   write_enable_latch;
  logic                   busy_flag;
  logic                   protect_from_bottom;
  logic                   bp_volatile_select;
  logic                   protection_freeze;
  logic                   erase_suspend_flag;
  logic                   program_suspend_flag;
  op_state_e              op_state;
  logic [CNT_W-1:0]       busy_count;
  logic                   hw_locked;
  logic                   regw_accept;
  logic                   prog_accept;
  logic                   erase_accept;
  logic [SECTOR_BITS:0]   prot_count;
  logic [SECTOR_BITS:0]   sector_ext;

  // ----------------------------------------------------------------
  // Pin synchroniser and command acceptance
  // ----------------------------------------------------------------
  // Write-protect pin passes two flops before use
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end
    else
    begin
      wp_meta <= write_protect_n;
      wp_sync <= wp_meta;
    end
  end

  // Hardware lock only when lock bit set and pin driven low
  assign hw_locked = status_write_lock && !wp_sync;

  // Commands need the latch and an idle engine
  assign regw_accept  = write_registers_cmd && write_enable_latch
                        && !hw_locked && (op_state == OP_IDLE);
  assign prog_accept  = program_cmd && write_enable_latch
                        && (op_state == OP_IDLE) && !target_protected;
  assign erase_accept = erase_cmd && write_enable_latch
                        && (op_state == OP_IDLE) && !target_protected;

  assign program_start = prog_accept;
  assign erase_start   = erase_accept;

  // ----------------------------------------------------------------
  // Operation engine and busy flag
  // ----------------------------------------------------------------
  // Track the running operation; register writes time out on a count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_state   <= OP_IDLE;
      busy_count <= '0;
    end
    else
    begin
      unique case (op_state)
        OP_IDLE:
        begin
          if (regw_accept)
          begin
            op_state   <= OP_REGW;
            busy_count <= WRITE_BUSY_LOAD;
          end
          else if (prog_accept)
            op_state <= OP_PROGRAM;
          else if (erase_accept)
            op_state <= OP_ERASE;
        end
        OP_REGW:
        begin
          if (busy_count <= CNT_W'(1))
            op_state <= OP_IDLE;
          busy_count <= busy_count - CNT_W'(1);
        end
        OP_PROGRAM, OP_ERASE:
        begin
          if (op_done)
            op_state <= OP_IDLE;
        end
      endcase
    end
  end

  // Busy while an operation runs and is not suspended
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      busy_flag <= FLAG_RESET;
    else
      busy_flag <= (op_state != OP_IDLE || regw_accept || prog_accept || erase_accept)
                   && !(erase_suspend || program_suspend)
                   && !(op_state != OP_REGW && op_done);
  end

  // ----------------------------------------------------------------
  // Write enable latch
  // ----------------------------------------------------------------
  // Set and clear commands only; register writes never touch it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      write_enable_latch <= FLAG_RESET;
    else if (set_write_enable_cmd)
      write_enable_latch <= 1'b1;
    else if (clear_write_enable_cmd)
      write_enable_latch <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Error and suspend flags
  // ----------------------------------------------------------------
  // Sticky error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      program_error_flag <= FLAG_RESET;
      erase_error_flag   <= FLAG_RESET;
    end
    else
    begin
      program_error_flag <= program_error
                            || (program_error_flag && !clear_status_cmd);
      erase_error_flag   <= erase_error
                            || (erase_error_flag && !clear_status_cmd);
    end
  end

  // Suspend flags mirror the engine's suspend modes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      erase_suspend_flag   <= FLAG_RESET;
      program_suspend_flag <= FLAG_RESET;
    end
    else
    begin
      erase_suspend_flag   <= erase_suspend;
      program_suspend_flag <= program_suspend;
    end
  end

  // ----------------------------------------------------------------
  // Writable status and configuration fields
  // ----------------------------------------------------------------
  // Lock bit, latency and quad enable follow accepted writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_write_lock <= FLAG_RESET;
      read_latency_code <= LATENCY_RESET;
      quad_io_enable    <= FLAG_RESET;
    end
    else if (regw_accept)
    begin
      status_write_lock <= wr_status_data[S1_LOCK_BIT];
      if (wr_config_valid)
      begin
        read_latency_code <= wr_config_data[CR_LAT_HI:CR_LAT_LO];
        quad_io_enable    <= wr_config_data[CR_QUAD_BIT];
      end
    end
  end

  // Protect bits land in the store chosen by the volatile select
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bp_nv  <= BP_NV_RESET;
      bp_vol <= BP_VOL_RESET;
    end
    else if (regw_accept && !protection_freeze)
    begin
      if (bp_volatile_select)
        bp_vol <= wr_status_data[S1_BP_HI:S1_BP_LO];
      else
        bp_nv  <= wr_status_data[S1_BP_HI:S1_BP_LO];
    end
  end

  assign block_protect_level = bp_volatile_select ? bp_vol : bp_nv;

  // One-time bits only go from zero to one; freeze is cleared by reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      protect_from_bottom <= FLAG_RESET;
      bp_volatile_select  <= FLAG_RESET;
      protection_freeze   <= FLAG_RESET;
    end
    else if (regw_accept && wr_config_valid)
    begin
      if (!protection_freeze && wr_config_data[CR_BOTTOM_BIT])
        protect_from_bottom <= 1'b1;
      if (!protection_freeze && wr_config_data[CR_VOLSEL_BIT])
        bp_volatile_select <= 1'b1;
      if (wr_config_data[CR_FREEZE_BIT])
        protection_freeze <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Protected range check
  // ----------------------------------------------------------------
  // Level k from 1 to 7 protects total >> (7 - k) sectors from one end; level 0 protects none
  always_comb
  begin
    prot_count = '0;
    if (block_protect_level != 3'h0)
      prot_count = SECTOR_TOTAL >> (3'h7 - block_protect_level);
  end

  assign sector_ext = {1'b0, target_sector};

  // Bottom start counts from sector zero, top start from the last
  assign target_protected = protect_from_bottom
                            ? (sector_ext < prot_count)
                            : (sector_ext >= SECTOR_TOTAL - prot_count);

  // ----------------------------------------------------------------
  // Register read views
  // ----------------------------------------------------------------
  // Read-only flags come from internal state only
  always_comb
  begin
    status_reg_one                        = 8'h00;
    status_reg_one[S1_LOCK_BIT]           = status_write_lock;
    status_reg_one[S1_PERR_BIT]           = program_error_flag;
    status_reg_one[S1_EERR_BIT]           = erase_error_flag;
    status_reg_one[S1_BP_HI:S1_BP_LO]     = block_protect_level;
    status_reg_one[S1_LATCH_BIT]          = write_enable_latch;
    status_reg_one[S1_BUSY_BIT]           = busy_flag;
  end

  // Reserved configuration bits stay zero
  always_comb
  begin
    config_reg                       = 8'h00;
    config_reg[CR_LAT_HI:CR_LAT_LO]  = read_latency_code;
    config_reg[CR_BOTTOM_BIT]        = protect_from_bottom;
    config_reg[CR_VOLSEL_BIT]        = bp_volatile_select;
    config_reg[CR_QUAD_BIT]          = quad_io_enable;
    config_reg[CR_FREEZE_BIT]        = protection_freeze;
  end

  // Only the suspend flags are live in status register two
  always_comb
  begin
    status_reg_two               = 8'h00;
    status_reg_two[S2_ESUS_BIT]  = erase_suspend_flag;
    status_reg_two[S2_PSUS_BIT]  = program_suspend_flag;
  end

endmodule

// [tb/flash_regs_assertions.sv]
// Checker for the flash status and configuration register set.
// Sees only the top module ports; bound to every instance below.
`timescale 1ns/100ps

module flash_regs_checker
#(
  parameter int WRITE_BUSY_CYCLES = 16
)
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       write_protect_n,
  input wire logic       set_write_enable_cmd,
  input wire logic       clear_write_enable_cmd,
  input wire logic       write_registers_cmd,
  input wire logic       program_error,
  input wire logic       erase_error,
  input wire logic       erase_suspend,
  input wire logic       program_suspend,
  input wire logic [7:0] status_reg_one,
  input wire logic [7:0] config_reg,
  input wire logic [7:0] status_reg_two,
  input wire logic [1:0] read_latency_code,
  input wire logic       quad_io_enable,
  input wire logic       target_protected,
  input wire logic       program_start
);
  // ----------------------------------------------------------------
  // Clocking and sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Register write that the device must take
  sequence write_taken;
    write_registers_cmd && status_reg_one[1] && !status_reg_one[0] && !status_reg_one[7];
  endsequence

  // Register write under lock with the pin low long enough to be seen
  sequence write_locked;
    (!write_protect_n)[*4] ##0 (write_registers_cmd && status_reg_one[7] && !status_reg_one[0]);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_latch_set: assert property
    (set_write_enable_cmd |=> status_reg_one[1])
    else $error("latch not set");
  chk_latch_clear: assert property
    (clear_write_enable_cmd && !set_write_enable_cmd |=> !status_reg_one[1])
    else $error("latch not cleared");
  chk_latch_hold: assert property
    (!set_write_enable_cmd && !clear_write_enable_cmd |=> $stable(status_reg_one[1]))
    else $error("latch moved without command");
  chk_no_latch_idle: assert property
    (!status_reg_one[1] && !status_reg_one[0] |=> !status_reg_one[0])
    else $error("operation started without latch");
  chk_start_gate: assert property
    (program_start |-> status_reg_one[1] && !status_reg_one[0] && !target_protected)
    else $error("program started when not allowed");
  // Busy shows from the edge after the write for the count plus the exit cycle
  chk_write_busy: assert property
    (write_taken |-> ##WRITE_BUSY_CYCLES status_reg_one[0] ##1 status_reg_one[0]
      ##1 !status_reg_one[0])
    else $error("busy length of register write wrong");
  chk_prog_busy: assert property
    (program_start |=> status_reg_one[0])
    else $error("busy not raised by program");
  chk_lock_ignore: assert property
    (write_locked |=> !status_reg_one[0] && $stable(status_reg_one[7:2])
      && $stable(config_reg))
    else $error("locked write was taken");
  chk_perr_set: assert property
    (program_error |=> status_reg_one[6])
    else $error("program error flag not set");
  chk_eerr_set: assert property
    (erase_error |=> status_reg_one[5])
    else $error("erase error flag not set");
  chk_suspend_flags: assert property
    (1 |=> status_reg_two[1] == $past(erase_suspend)
      && status_reg_two[0] == $past(program_suspend))
    else $error("suspend flags do not follow");
  chk_reserved_zero: assert property
    (status_reg_two[7:2] == 6'h00 && !config_reg[4] && !config_reg[2])
    else $error("reserved bit set");
  chk_freeze_hold: assert property
    (config_reg[0] |=> $stable(status_reg_one[4:2]) && $stable(config_reg[5])
      && config_reg[0])
    else $error("frozen field changed");
  chk_cfg_outputs: assert property
    (read_latency_code == config_reg[7:6] && quad_io_enable == config_reg[1])
    else $error("config outputs differ from register");
endmodule

bind flash_status_config_regs flash_regs_checker
  #(.WRITE_BUSY_CYCLES(WRITE_BUSY_CYCLES)) flash_regs_checker_inst
(
  .clk, .rstn, .write_protect_n, .set_write_enable_cmd, .clear_write_enable_cmd,
  .write_registers_cmd, .program_error, .erase_error, .erase_suspend, .program_suspend,
  .status_reg_one, .config_reg, .status_reg_two, .read_latency_code, .quad_io_enable,
  .target_protected, .program_start
);

// [tb/array_engine_model.sv]
// Behavioural array engine on the far side of program and erase.
// Assumes the block's start pulses; ends each run with a done pulse.
`timescale 1ns/100ps

module array_engine_model
#(
  parameter int OP_CYCLES = 6
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic program_start,
  input  wire logic erase_start,
  input  wire logic fail_next,
  output logic      op_done,
  output logic      program_error,
  output logic      erase_error
);
  logic [7:0] count;
  logic       erasing;

  // Counts a run down, then pulses done and an error when asked to fail
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      {count, erasing, op_done, program_error, erase_error} <= '0;
    else if (program_start || erase_start)
    begin
      count   <= 8'(OP_CYCLES);
      erasing <= erase_start && !program_start;
    end
    else
    begin
      count         <= (count != 8'h00) ? count - 8'h01 : count;
      op_done       <= count == 8'h01;
      program_error <= count == 8'h01 && fail_next && !erasing;
      erase_error   <= count == 8'h01 && fail_next && erasing;
    end
  end
endmodule

// [tb/flash_status_config_regs_tb.sv]
// Self-checking bench for the flash status and configuration registers.
// Assumes the array engine model and the bound checker.
`timescale 1ns/100ps

module flash_status_config_regs_tb;
  logic       clk = 0, rstn = 0, write_protect_n = 1, fail_next = 0;
  logic       set_write_enable_cmd = 0, clear_write_enable_cmd = 0, write_registers_cmd = 0;
  logic [7:0] wr_status_data = 8'h00, wr_config_data = 8'h00;
  logic       wr_config_valid = 0, clear_status_cmd = 0, program_cmd = 0, erase_cmd = 0;
  logic [3:0] target_sector = 4'h0;
  logic       erase_suspend = 0, program_suspend = 0;
  logic       op_done, program_error, erase_error, quad_io_enable, target_protected;
  logic       program_start, erase_start;
  logic [7:0] status_reg_one, config_reg, status_reg_two;
  logic [1:0] read_latency_code;
  int         mismatches = 0, total_checks = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  flash_status_config_regs #(.SECTOR_BITS(4), .WRITE_BUSY_CYCLES(2)) flash_status_config_regs_inst
  (
    .clk, .rstn, .write_protect_n, .set_write_enable_cmd, .clear_write_enable_cmd,
    .write_registers_cmd, .wr_status_data, .wr_config_data, .wr_config_valid,
    .clear_status_cmd, .program_cmd, .erase_cmd, .target_sector, .op_done, .program_error,
    .erase_error, .erase_suspend, .program_suspend, .status_reg_one, .config_reg,
    .status_reg_two, .read_latency_code, .quad_io_enable, .target_protected,
    .program_start, .erase_start
  );

  array_engine_model array_engine_model_inst
  (
    .clk, .rstn, .program_start, .erase_start, .fail_next, .op_done, .program_error,
    .erase_error
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Set or clear the write enable latch
  task automatic latch(input logic on);
    set_write_enable_cmd = on;
    clear_write_enable_cmd = !on;
    tick(1);
    {set_write_enable_cmd, clear_write_enable_cmd} = 2'b00;
  endtask

  // Register write; returns half a cycle after the request edge
  task automatic reg_write(input logic [7:0] sd, input logic [7:0] cd);
    {write_registers_cmd, wr_status_data, wr_config_data, wr_config_valid} = {1'b1, sd, cd, 1'b1};
    tick(1);
    {write_registers_cmd, wr_config_valid} = 2'b00;
  endtask

  // Bounded wait for busy to fall
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && status_reg_one[0] !== 1'b0; i++)
      tick(1);
    if (i == 40)
    begin
      mismatches++;
      complete_run();
    end
  endtask

  // Program or erase request, checking whether it is taken
  task automatic op(input logic ers, input logic [3:0] sec, input logic exp);
    {erase_cmd, program_cmd, target_sector} = {ers, !ers, sec};
    #1;
    check({7'h00, ers ? erase_start : program_start}, {7'h00, exp});
    tick(1);
    {erase_cmd, program_cmd} = 2'b00;
    tick(1);  // Let an edge pass before the next request
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(5);
    rstn = 1;
    tick(1);
    check(status_reg_one, 8'h00);
    check(config_reg, 8'h00);
    check(status_reg_two, 8'h00);
    reg_write(8'hFF, 8'hD6);
    check(status_reg_one, 8'h00);
    latch(1);
    check(status_reg_one, 8'h02);
    reg_write(8'hFF, 8'hD6);
    check(status_reg_one, 8'h9F);
    check(config_reg, 8'hC2);
    check({5'h00, read_latency_code, quad_io_enable}, 8'h07);
    wait_idle();
    check(status_reg_one, 8'h9E);
    latch(0);
    reg_write(8'h00, 8'h00);
    check(status_reg_one, 8'h9C);
    latch(1);
    write_protect_n = 0;
    tick(3);
    reg_write(8'h00, 8'h00);
    check(status_reg_one, 8'h9E);
    check(config_reg, 8'hC2);
    write_protect_n = 1;
    tick(3);
    reg_write(8'h14, 8'h20);
    check(status_reg_one, 8'h17);
    wait_idle();
    check(config_reg, 8'h20);
    op(0, 4'h3, 0);
    op(1, 4'h0, 0);
    op(0, 4'h4, 1);
    check(status_reg_one, 8'h17);
    wait_idle();
    for (int e = 0; e < 2; e++)
    begin
      fail_next = 1;
      op(e[0], 4'hF, 1);
      wait_idle();
      check(status_reg_one, e ? 8'h36 : 8'h56);
      {fail_next, clear_status_cmd} = 2'b01;
      tick(1);
      clear_status_cmd = 0;
      check(status_reg_one, 8'h16);
    end
    // Volatile select shows the volatile protect store at its all-ones default
    reg_write(8'h14, 8'h28);
    wait_idle();
    check(status_reg_one, 8'h1E);
    check(config_reg, 8'h28);
    reg_write(8'h14, 8'h21);
    wait_idle();
    reg_write(8'h00, 8'h00);
    wait_idle();
    check(status_reg_one, 8'h16);
    check(config_reg, 8'h29);
    {erase_suspend, program_suspend} = 2'b10;
    tick(2);
    check(status_reg_two, 8'h02);
    {erase_suspend, program_suspend} = 2'b01;
    tick(2);
    check(status_reg_two, 8'h01);
    complete_run();
  end
endmodule
